//--- core/excitation_current_control.sv
// Purpose: current-source control register and analog switch drive
// Assumes: sfr bus is byte wide, synchronous, one-cycle write strobe
// Notes: no single-bit addressing; read data registered one cycle late
`timescale 1ns/1ps

module excitation_current_control (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic burnout_pos_on,
    output logic burnout_neg_on,
    output logic aux_current_correction,
    output logic primary_current_correction,
    output logic src1_to_first_excitation_pin,
    output logic src1_to_second_excitation_pin,
    output logic src2_to_first_excitation_pin,
    output logic src2_to_second_excitation_pin
);
    logic [7:0] ctrl_r;
    logic sel;

    assign sel = (sfr_addr == excitation_current_pkg::ICC_ADDR);

    // whole-byte write only; reserved bit masked off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= excitation_current_pkg::ICC_RESET;
        end else if (sfr_wr && sel) begin
            ctrl_r <= sfr_wdata & excitation_current_pkg::ICC_WRITE_MASK;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sel) begin
            sfr_rdata <= ctrl_r & excitation_current_pkg::ICC_WRITE_MASK;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // switch drive; each source routed independently, so both may share a pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            burnout_pos_on <= 1'b0;
            burnout_neg_on <= 1'b0;
            aux_current_correction <= 1'b0;
            primary_current_correction <= 1'b0;
            src1_to_first_excitation_pin <= 1'b0;
            src1_to_second_excitation_pin <= 1'b0;
            src2_to_first_excitation_pin <= 1'b0;
            src2_to_second_excitation_pin <= 1'b0;
        end else begin
            burnout_pos_on <= ctrl_r[excitation_current_pkg::BIT_BURNOUT];
            burnout_neg_on <= ctrl_r[excitation_current_pkg::BIT_BURNOUT];
            aux_current_correction <=
                ctrl_r[excitation_current_pkg::BIT_AUX_CORR];
            primary_current_correction <=
                ctrl_r[excitation_current_pkg::BIT_PRI_CORR];
            src1_to_first_excitation_pin <=
                ctrl_r[excitation_current_pkg::BIT_SRC1_EN] &&
                !ctrl_r[excitation_current_pkg::BIT_SRC1_PIN];
            src1_to_second_excitation_pin <=
                ctrl_r[excitation_current_pkg::BIT_SRC1_EN] &&
                ctrl_r[excitation_current_pkg::BIT_SRC1_PIN];
            src2_to_first_excitation_pin <=
                ctrl_r[excitation_current_pkg::BIT_SRC2_EN] &&
                ctrl_r[excitation_current_pkg::BIT_SRC2_PIN];
            src2_to_second_excitation_pin <=
                ctrl_r[excitation_current_pkg::BIT_SRC2_EN] &&
                !ctrl_r[excitation_current_pkg::BIT_SRC2_PIN];
        end
    end

    AST_RESET_VALUE: assert property (@(posedge core_clk)
        $fell(rst) |-> ctrl_r == 8'h00)
        else $error("control register not zero after reset");
    AST_RESERVED_ZERO: assert property (@(posedge core_clk)
        disable iff (rst)
        sfr_rdata[7] == 1'b0)
        else $error("reserved bit read as one");
    AST_READBACK: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel) ##1 (sfr_rd && sel && !sfr_wr) |=>
        sfr_rdata == ($past(sfr_wdata, 2) & 8'h7f))
        else $error("readback differs from write");
    AST_BURNOUT: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel) |=> ##1
        (burnout_pos_on == $past(sfr_wdata[6], 2)) &&
        (burnout_neg_on == burnout_pos_on))
        else $error("burnout sources not following bit");
    AST_AUX_CORR: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel) |=> ##1
        aux_current_correction == $past(sfr_wdata[5], 2))
        else $error("aux correction not following bit");
    AST_PRI_CORR: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel) |=> ##1
        primary_current_correction == $past(sfr_wdata[4], 2))
        else $error("primary correction not following bit");
    AST_SRC2_ROUTE: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel && sfr_wdata[1]) |=> ##1
        (src2_to_first_excitation_pin == $past(sfr_wdata[3], 2)) &&
        (src2_to_second_excitation_pin != src2_to_first_excitation_pin))
        else $error("source two routed wrongly");
    AST_SRC1_ROUTE: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel && sfr_wdata[0]) |=> ##1
        (src1_to_second_excitation_pin == $past(sfr_wdata[2], 2)) &&
        (src1_to_first_excitation_pin != src1_to_second_excitation_pin))
        else $error("source one routed wrongly");
    AST_SRC2_OFF: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel && !sfr_wdata[1]) |=> ##1
        !src2_to_first_excitation_pin && !src2_to_second_excitation_pin)
        else $error("source two on while disabled");
    AST_SRC1_OFF: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel && !sfr_wdata[0]) |=> ##1
        !src1_to_first_excitation_pin && !src1_to_second_excitation_pin)
        else $error("source one on while disabled");
    AST_SHARED_PIN: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_wr && sel && sfr_wdata[3:0] == 4'h7) |=> ##1
        src1_to_second_excitation_pin && src2_to_second_excitation_pin)
        else $error("both sources not on shared pin");

    // register and read port checks
    AST_RESET_OUTPUTS: assert property (@(posedge core_clk)
        $fell(rst) |->
        !burnout_pos_on && !burnout_neg_on && !aux_current_correction &&
        !primary_current_correction && sfr_rdata == 8'h00)
        else $error("outputs not zero after reset");

    AST_RDATA_IDLE: assert property (@(posedge core_clk)
        disable iff (rst)
        !(sfr_rd && sel) |=> sfr_rdata == 8'h00)
        else $error("read data not zero without a read");

    AST_READ_OTHER: assert property (@(posedge core_clk)
        disable iff (rst)
        (sfr_rd && !sel) |=> sfr_rdata == 8'h00)
        else $error("other address read not zero");

    AST_READ_SAME_CYCLE: assert property (@(posedge core_clk)
        disable iff (rst)
        (sfr_rd && sfr_wr && sel) |=>
        sfr_rdata == ($past(ctrl_r) & excitation_current_pkg::ICC_WRITE_MASK))
        else $error("read beside write did not return old value");

    AST_CTRL_HOLD: assert property (@(posedge core_clk)
        disable iff (rst)
        !(sfr_wr && sel) |=> $stable(ctrl_r))
        else $error("control register changed without a write");

    AST_CTRL_WRITE: assert property (@(posedge core_clk)
        disable iff (rst)
        (sfr_wr && sel) |=>
        ctrl_r == ($past(sfr_wdata) & excitation_current_pkg::ICC_WRITE_MASK))
        else $error("control register not loaded from write");

    AST_CTRL_RESERVED: assert property (@(posedge core_clk)
        disable iff (rst)
        ctrl_r[7] == 1'b0)
        else $error("reserved register bit set");

    // drive checks; each drive follows the register one edge later
    AST_BURNOUT_PAIR: assert property (@(posedge core_clk)
        disable iff (rst)
        burnout_pos_on == burnout_neg_on)
        else $error("burnout sources disagree");

    AST_BURNOUT_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        burnout_pos_on ==
        $past(ctrl_r[excitation_current_pkg::BIT_BURNOUT]))
        else $error("burnout drive not following register");

    AST_AUX_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        aux_current_correction ==
        $past(ctrl_r[excitation_current_pkg::BIT_AUX_CORR]))
        else $error("aux correction not following register");

    AST_PRI_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        primary_current_correction ==
        $past(ctrl_r[excitation_current_pkg::BIT_PRI_CORR]))
        else $error("primary correction not following register");

    AST_SRC1_EXCL: assert property (@(posedge core_clk)
        disable iff (rst)
        !(src1_to_first_excitation_pin && src1_to_second_excitation_pin))
        else $error("source one on both pins");

    AST_SRC2_EXCL: assert property (@(posedge core_clk)
        disable iff (rst)
        !(src2_to_first_excitation_pin && src2_to_second_excitation_pin))
        else $error("source two on both pins");

    AST_SRC1_FIRST_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        src1_to_first_excitation_pin ==
        $past(ctrl_r[excitation_current_pkg::BIT_SRC1_EN] &&
        !ctrl_r[excitation_current_pkg::BIT_SRC1_PIN]))
        else $error("source one first pin drive wrong");

    AST_SRC1_SECOND_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        src1_to_second_excitation_pin ==
        $past(ctrl_r[excitation_current_pkg::BIT_SRC1_EN] &&
        ctrl_r[excitation_current_pkg::BIT_SRC1_PIN]))
        else $error("source one second pin drive wrong");

    AST_SRC2_FIRST_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        src2_to_first_excitation_pin ==
        $past(ctrl_r[excitation_current_pkg::BIT_SRC2_EN] &&
        ctrl_r[excitation_current_pkg::BIT_SRC2_PIN]))
        else $error("source two first pin drive wrong");

    AST_SRC2_SECOND_FOLLOW: assert property (@(posedge core_clk)
        disable iff (rst)
        src2_to_second_excitation_pin ==
        $past(ctrl_r[excitation_current_pkg::BIT_SRC2_EN] &&
        !ctrl_r[excitation_current_pkg::BIT_SRC2_PIN]))
        else $error("source two second pin drive wrong");

    AST_SHARED_FIRST: assert property (@(posedge core_clk)
        disable iff (rst)
        (sfr_wr && sel && sfr_wdata[3:0] == 4'hb) |=> ##1
        src1_to_first_excitation_pin && src2_to_first_excitation_pin)
        else $error("both sources not on first pin");
endmodule : excitation_current_control

//--- shared/excitation_current_pkg.sv
// Purpose: constants for the excitation current control register
// Assumes: one 8-bit special function register on the core's sfr port
// Notes: bit 7 is reserved and always reads as zero
package excitation_current_pkg;
    localparam logic [7:0] ICC_ADDR = 8'hd5;
    localparam logic [7:0] ICC_RESET = 8'h00;
    localparam logic [7:0] ICC_WRITE_MASK = 8'h7f;
    localparam int BIT_BURNOUT = 6;
    localparam int BIT_AUX_CORR = 5;
    localparam int BIT_PRI_CORR = 4;
    localparam int BIT_SRC2_PIN = 3;
    localparam int BIT_SRC1_PIN = 2;
    localparam int BIT_SRC2_EN = 1;
    localparam int BIT_SRC1_EN = 0;
endpackage : excitation_current_pkg

//--- tb/excitation_pin_model.sv
// Purpose: far-side model of the excitation current switches
// Assumes: each closed switch passes one 200 uA source
// Notes: sw is src1 first, src1 second, src2 first, src2 second
`timescale 1ns/1ps
module excitation_pin_model (
    input wire logic [3:0] sw,
    output logic [15:0] first_pin_ua,
    output logic [15:0] second_pin_ua
);
    localparam int SRC_UA = 200;
    assign first_pin_ua = 16'(SRC_UA * (int'(sw[3]) + int'(sw[1])));
    assign second_pin_ua = 16'(SRC_UA * (int'(sw[2]) + int'(sw[0])));
endmodule : excitation_pin_model

//--- tb/testbench.sv
// Purpose: self-checking bench for the excitation current register
// Assumes: sfr strobes driven on falling edges, one cycle wide
// Notes: outs packs all switch outputs, burnout first
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [7:0] outs;
    logic [15:0] p1_ua;
    logic [15:0] p2_ua;
    logic [7:0] d;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [7:0] A = excitation_current_pkg::ICC_ADDR;
    localparam logic [7:0] M = excitation_current_pkg::ICC_WRITE_MASK;
    excitation_current_control u_dut (.core_clk(core_clk), .rst(rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .burnout_pos_on(outs[7]), .burnout_neg_on(outs[6]),
        .aux_current_correction(outs[5]),
        .primary_current_correction(outs[4]),
        .src1_to_first_excitation_pin(outs[3]),
        .src1_to_second_excitation_pin(outs[2]),
        .src2_to_first_excitation_pin(outs[1]),
        .src2_to_second_excitation_pin(outs[0]));
    excitation_pin_model u_pins (.sw(outs[3:0]), .first_pin_ua(p1_ua),
        .second_pin_ua(p2_ua));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            conclude();
        end
    end
    function automatic logic [7:0] expo(input logic [7:0] v);
        return {v[6], v[6], v[5], v[4], v[0] & ~v[2], v[0] & v[2],
            v[1] & v[3], v[1] & ~v[3]};
    endfunction : expo
    task automatic check(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, v);
        @(negedge core_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
        @(negedge core_clk) sfr_wr = 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk) {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge core_clk) sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic test_reset();
        rd(A);
        check("reset value", d, excitation_current_pkg::ICC_RESET);
        check("reset outputs", outs, 8'h00);
        $display("test reset done");
    endtask : test_reset
    task automatic test_single_bits();
        logic [7:0] v;
        for (int i = 0; i < 7; i++) begin
            v = 8'(1 << i);
            wr(A, v);
            rd(A);
            check("readback", d, 16'(1 << i));
            check("switches", outs, expo(v));
        end
        wr(A, 8'h00);
        check("all off", outs, 8'h00);
        $display("test single bits done");
    endtask : test_single_bits
    task automatic test_shared_pin();
        logic [7:0] v;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'h0b : 8'h07;
            wr(A, v);
            check("routing", outs, expo(v));
            check("pin current", k == 0 ? p1_ua : p2_ua, 16'd400);
        end
        $display("test shared pin done");
    endtask : test_shared_pin
    task automatic test_back_to_back();
        @(negedge core_clk) {sfr_addr, sfr_wdata, sfr_wr} = {A, 8'h5a, 1'b1};
        @(negedge core_clk) {sfr_wr, sfr_rd} = 2'b01;
        @(negedge core_clk) sfr_rd = 1'b0;
        check("back to back", sfr_rdata, 8'h5a);
        @(negedge core_clk) {sfr_wdata, sfr_wr, sfr_rd} = {8'h23, 2'b11};
        @(negedge core_clk) {sfr_wr, sfr_rd} = 2'b00;
        check("same cycle read", sfr_rdata, 8'h5a);
        rd(A);
        check("after same cycle", d, 8'h23);
        $display("test back to back done");
    endtask : test_back_to_back
    task automatic test_reserved();
        wr(A, 8'hff);
        wr(A - 8'h01, 8'h00);
        rd(A);
        check("reserved bit", d, M);
        check("other write", outs, expo(8'hff));
        rd(A - 8'h01);
        check("other address", d, 8'h00);
        $display("test reserved and decode done");
    endtask : test_reserved
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        test_reset();
        test_single_bits();
        test_shared_pin();
        test_back_to_back();
        test_reserved();
        conclude();
    end
endmodule : testbench
